// ---- rtl/roc_ctrl.sv ----
// Reader operating-state controller with AXI4-Lite register access
// What this block does
// - RF test configuration: field on after reset, random bytes sent continuously.
// - Test framing and speed come from two select pins.
// - Temperature sensor stays disabled in RF test configuration.
// - Standard configuration runs a five-state operating machine.
// - UART link starts in Standby and waits for a command.
// - After reset processor is in normal power; RF interface off only for a UART link in standard configuration.
// - USB only: RF-on in Standby or Reader goes to discovery.
// - Card activate command in Standby or discovery goes to Reader.
// - Open session in Standby, discovery or Reader goes to Transparent.
// - RF-off in discovery or Reader returns to Standby.
// - Open session in Transparent: USB to discovery, UART to Standby.
// - USB suspend or UART power-down command enters Suspend.
// - Leaving Suspend returns to previous state on resume or wake.
// - Suspend also parks the general-purpose I/O port.
// - Discovery exists only on USB and is the USB boot state.
// - Discovery loops A, pause1, 4B, B-prime, 2B, F424, F212, final_pause_phase.
// - Each phase can be disabled except the final pause.
// - RF field is off during every pause phase.
// - Card activation forwards answer-to-reset and starts presence checks.
// - Card removal is reported and the loop restarts at phase A.
// - Host sets retries, final pause length, disabled phases, stop.
`timescale 1ns/1ps
module roc_ctrl
   import roc_pkg::*;
#(
   parameter int PRES_CYCLES = PRES_CYC
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        mode_sel_pin_a,
   input  wire logic        mode_sel_pin_b,
   input  wire logic        tx_select_pin_a,
   input  wire logic        tx_select_pin_b,
   input  wire logic        link_is_usb,
   input  wire logic        usb_suspend,
   input  wire logic        uart_wake,
   input  wire logic        card_activated,
   input  wire logic        card_absent,
   output logic             rf_field_on,
   output logic [1:0]       tx_framing,
   output logic [7:0]       tx_data,
   output logic             tx_valid,
   output logic             temp_sensor_en,
   output logic             cpu_low_power,
   output logic             gpio_park,
   output logic [2:0]       op_state,
   output logic             probe_en,
   output logic [2:0]       probe_tech,
   output logic             card_answer_to_reset,
   output logic             presence_chk
);
   typedef struct packed {
      logic [1:0]  boot_cnt;
      logic        rf_on_test_config;
      logic        usb;
      logic [1:0]  txf;
      roc_state_e  st;
      roc_state_e  prev;
      roc_phase_e  ph;
      logic        card;
      logic [19:0] cnt;
      logic [3:0]  tries;
      logic [31:0] cfg;
      logic [1:0]  evt;
      logic        ans;
      logic        chk;
      logic        txv;
      logic        aw_got;
      logic        w_got;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } roc_s;

   roc_s        s_r;
   roc_s        s_nxt;
   logic [6:0]  pins_s;
   logic        usb_susp_s;
   logic        uart_wake_s;
   logic        booting;
   logic        wr_go;
   logic        cmd_fire;
   logic [7:0]  cmd_code;
   logic        go_susp;
   logic        wake;
   logic        ph_en;
   logic        is_pause;
   logic        retry_done;
   logic [19:0] ph_limit;

   roc_sync #(.W(7)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({mode_sel_pin_a, mode_sel_pin_b, tx_select_pin_a, tx_select_pin_b,
                 link_is_usb, usb_suspend, uart_wake}),
      .dout    (pins_s)
   );

   roc_lfsr u_lfsr (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .step     (s_r.txv),
      .rnd_byte (tx_data)
   );

   assign usb_susp_s  = pins_s[1];
   assign uart_wake_s = pins_s[0];
   assign booting     = (s_r.boot_cnt != BOOT_CYC);

   // ------------------------------------------------------------
   // Bus handshakes and decoded commands
   // ------------------------------------------------------------
   assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
   assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
   assign s_axi_arready = !s_r.rvalid;
   assign wr_go         = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   // Commands are ignored until straps are taken and in RF test mode
   assign cmd_fire = wr_go && (s_r.awaddr == ADDR_CMD) && s_r.wstrb[0]
                     && !booting && !s_r.rf_on_test_config;
   assign cmd_code = s_r.wdata[7:0];
   assign go_susp = s_r.usb ? usb_susp_s : (cmd_fire && cmd_code == CMD_PWR_DN);
   assign wake    = s_r.usb ? !usb_susp_s : uart_wake_s;
   assign ph_en    = (s_r.ph == PH_P2) || s_r.cfg[s_r.ph];
   assign is_pause = (s_r.ph == PH_P1) || (s_r.ph == PH_P2);
   assign retry_done = ({1'b0, s_r.tries} + 5'h01) >= {1'b0, s_r.cfg[CFG_RETRY_LSB +: 4]};
   always_comb begin
      unique case (s_r.ph)
         PH_P1:   ph_limit = 20'(PAUSE1_CYC - 1);
         PH_P2:   ph_limit = 20'(s_r.cfg[CFG_P2_LSB +: 8] * P2_UNIT_CYC);
         default: ph_limit = 20'(ATTEMPT_CYC - 1);
      endcase
   end

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      s_nxt     = s_r;
      s_nxt.ans = 1'b0;
      s_nxt.chk = 1'b0;
      s_nxt.txv = 1'b0;

      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got  = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = RESP_OKAY;
         unique case (s_r.awaddr)
            ADDR_CMD, ADDR_STATUS: ;
            ADDR_CFG: begin
               for (int b = 0; b < 4; b++) begin
                  if (s_r.wstrb[b]) begin
                     s_nxt.cfg[8*b +: 8] = s_r.wdata[8*b +: 8];
                  end
               end
            end
            // Clear applied before hardware sets so that a set wins
            ADDR_EVT: if (s_r.wstrb[0]) begin
               s_nxt.evt = s_r.evt & ~s_r.wdata[1:0];
            end
            default: s_nxt.bresp = RESP_SLVERR;
         endcase
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = RESP_OKAY;
         s_nxt.rdata  = 32'h0000_0000;
         unique case (s_axi_araddr)
            ADDR_CMD: ;
            ADDR_STATUS: begin
               s_nxt.rdata[ST_STATE_LSB +: 3] = s_r.st;
               s_nxt.rdata[ST_PREV_LSB +: 3]  = s_r.prev;
               s_nxt.rdata[ST_PHASE_LSB +: 3] = s_r.ph;
               s_nxt.rdata[ST_TEST_BIT]       = s_r.rf_on_test_config;
               s_nxt.rdata[ST_USB_BIT]        = s_r.usb;
               s_nxt.rdata[ST_CARD_BIT]       = s_r.card;
            end
            ADDR_CFG: s_nxt.rdata = s_r.cfg;
            ADDR_EVT: s_nxt.rdata[1:0] = s_r.evt;
            default:  s_nxt.rresp = RESP_SLVERR;
         endcase
      end

      if (booting) begin
         // Straps are valid once the synchroniser has filled
         s_nxt.boot_cnt = s_r.boot_cnt + 2'h1;
         if (s_nxt.boot_cnt == BOOT_CYC) begin
            // test mode selected by mode pins 0,1
            s_nxt.rf_on_test_config = !pins_s[6] && pins_s[5];
            s_nxt.usb = pins_s[2];
            unique case (pins_s[4:3])
               2'h1:    s_nxt.txf = TXF_F212;
               2'h2:    s_nxt.txf = TXF_F424;
               default: s_nxt.txf = TXF_A106;
            endcase
            s_nxt.st = (pins_s[2] && !s_nxt.rf_on_test_config) ? ST_DISC : ST_STANDBY;
         end
      end else if (s_r.rf_on_test_config) begin
         s_nxt.cnt = s_r.cnt + 20'h00001;
         if (s_r.cnt == 20'(BYTE_CYC - 1)) begin
            s_nxt.cnt = 20'h00000;
            s_nxt.txv = 1'b1;
         end
      end else begin
         if (s_r.st == ST_SUSPEND) begin
            if (wake) begin
               s_nxt.st = s_r.prev;
            end
         end else if (go_susp) begin
            s_nxt.prev = s_r.st;
            s_nxt.st   = ST_SUSPEND;
         end else if (cmd_fire) begin
            unique case (s_r.st)
               ST_STANDBY: begin
                  if (cmd_code == CMD_RF_ON && s_r.usb) s_nxt.st = ST_DISC;
                  if (cmd_code == CMD_ACT) s_nxt.st = ST_READER;
                  if (cmd_code == CMD_OPEN) s_nxt.st = ST_TRANSP;
               end
               ST_DISC: begin
                  if (cmd_code == CMD_RF_OFF) s_nxt.st = ST_STANDBY;
                  if (cmd_code == CMD_ACT) s_nxt.st = ST_READER;
                  if (cmd_code == CMD_OPEN) s_nxt.st = ST_TRANSP;
               end
               ST_READER: begin
                  if (cmd_code == CMD_RF_OFF) s_nxt.st = ST_STANDBY;
                  if (cmd_code == CMD_RF_ON && s_r.usb) s_nxt.st = ST_DISC;
                  if (cmd_code == CMD_OPEN) s_nxt.st = ST_TRANSP;
               end
               ST_TRANSP: begin
                  if (cmd_code == CMD_OPEN) s_nxt.st = s_r.usb ? ST_DISC : ST_STANDBY;
               end
               ST_SUSPEND: ;
            endcase
         end

         // Discovery engine; restarts from phase A whenever it is re-entered
         if (s_r.st != ST_DISC || s_r.cfg[CFG_STOP_BIT]) begin
            s_nxt.card  = 1'b0;
            s_nxt.ph    = PH_A;
            s_nxt.cnt   = 20'h00000;
            s_nxt.tries = 4'h0;
         end else if (s_r.card) begin
            s_nxt.cnt = s_r.cnt + 20'h00001;
            if (s_r.cnt == 20'(PRES_CYCLES - 1)) begin
               s_nxt.cnt = 20'h00000;
               s_nxt.chk = 1'b1;
            end
            if (card_absent) begin
               s_nxt.card          = 1'b0;
               s_nxt.evt[EV_REMOVE] = 1'b1;
               s_nxt.ph            = PH_A;
               s_nxt.cnt           = 20'h00000;
               s_nxt.tries         = 4'h0;
            end
         end else if (!ph_en) begin
            s_nxt.ph    = roc_phase_e'(s_r.ph + 3'h1);
            s_nxt.tries = 4'h0;
         end else if (!is_pause && card_activated) begin
            s_nxt.card           = 1'b1;
            s_nxt.ans            = 1'b1;
            s_nxt.evt[EV_ARRIVE] = 1'b1;
            s_nxt.cnt            = 20'h00000;
         end else begin
            s_nxt.cnt = s_r.cnt + 20'h00001;
            if (s_r.cnt >= ph_limit) begin
               s_nxt.cnt = 20'h00000;
               s_nxt.tries = s_r.tries + 4'h1;
               // fixed phase order, retries per technology
               if (is_pause || retry_done) begin
                  s_nxt.ph    = roc_phase_e'(s_r.ph + 3'h1);
                  s_nxt.tries = 4'h0;
               end
            end
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r     <= '0;
         s_r.st  <= ST_STANDBY;
         s_r.prev <= ST_STANDBY;
         s_r.ph  <= PH_A;
         s_r.cfg <= CFG_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp  = s_r.bresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata  = s_r.rdata;
   assign s_axi_rresp  = s_r.rresp;
   // RF off in pauses; off in Standby after reset
   assign rf_field_on = s_r.rf_on_test_config
                        || (s_r.st == ST_DISC && !s_r.cfg[CFG_STOP_BIT] && !is_pause)
                        || s_r.st == ST_READER || s_r.st == ST_TRANSP;
   assign tx_framing  = s_r.txf;
   assign tx_valid    = s_r.txv;
   assign temp_sensor_en = !s_r.rf_on_test_config;
   // low power and parked I/O only in Suspend
   assign cpu_low_power  = (s_r.st == ST_SUSPEND);
   assign gpio_park      = (s_r.st == ST_SUSPEND);
   assign op_state       = s_r.st;
   assign probe_en   = s_r.st == ST_DISC && !s_r.cfg[CFG_STOP_BIT] && !s_r.card
                       && !is_pause && ph_en;
   assign probe_tech = s_r.ph;
   assign card_answer_to_reset = s_r.ans;
   assign presence_chk = s_r.chk;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   localparam int A_BYTE = BYTE_CYC;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_in_susp;
      s_r.st == ST_SUSPEND;
   endsequence
   sequence s_left_susp;
      s_in_susp ##1 s_r.st != ST_SUSPEND;
   endsequence

   property p_test_rf;
      s_r.rf_on_test_config && tx_valid |=> !tx_valid ##[1:A_BYTE] tx_valid && rf_field_on;
   endproperty
   a_test_rf: assert property (p_test_rf) else $error("test byte pacing lost");
   property p_txf;
      // Framing is latched on the last boot edge, so the first idle edge is skipped
      !booting && !$past(booting) |-> $stable(tx_framing);
   endproperty
   a_txf: assert property (p_txf) else $error("framing changed after boot");
   property p_temp;
      s_r.rf_on_test_config |-> !temp_sensor_en && rf_field_on;
   endproperty
   a_temp: assert property (p_temp) else $error("sensor on in test mode");
   property p_act;
      cmd_fire && cmd_code == CMD_ACT && !go_susp
      && (s_r.st == ST_STANDBY || s_r.st == ST_DISC) |=> op_state == ST_READER;
   endproperty
   a_act: assert property (p_act) else $error("activate did not reach Reader");
   property p_off;
      cmd_fire && cmd_code == CMD_RF_OFF && !go_susp
      && (s_r.st == ST_READER || s_r.st == ST_DISC) |=> op_state == ST_STANDBY;
   endproperty
   a_off: assert property (p_off) else $error("field off did not reach Standby");
   property p_uart_on;
      !s_r.usb |-> op_state != ST_DISC;
   endproperty
   a_uart_on: assert property (p_uart_on) else $error("discovery on UART link");
   property p_susp;
      s_r.usb && usb_susp_s && !booting && !s_r.rf_on_test_config |=> s_in_susp;
   endproperty
   a_susp: assert property (p_susp) else $error("USB suspend ignored");
   property p_resume;
      s_left_susp |-> op_state == $past(s_r.prev);
   endproperty
   a_resume: assert property (p_resume) else $error("resume to wrong state");
   property p_pause;
      s_r.st == ST_DISC && is_pause |-> !rf_field_on;
   endproperty
   a_pause: assert property (p_pause) else $error("field on in pause");
   property p_remove;
      s_r.st == ST_DISC && s_r.card && card_absent && !s_r.cfg[CFG_STOP_BIT] && !go_susp
      && !cmd_fire |=> s_r.evt[EV_REMOVE] && !s_r.card && s_r.ph == PH_A;
   endproperty
   a_remove: assert property (p_remove) else $error("removal not handled");
endmodule : roc_ctrl

// ---- common/roc_pkg.sv ----
// Constants and types shared by the reader operating-state controller
package roc_pkg;
   localparam int CLK_HZ       = 10_000_000;
   localparam int CYC_PER_US   = CLK_HZ / 1_000_000;
   localparam int ATTEMPT_US   = 100;
   localparam int ATTEMPT_CYC  = ATTEMPT_US * CYC_PER_US;
   localparam int PAUSE1_US    = 100;
   localparam int PAUSE1_CYC   = PAUSE1_US * CYC_PER_US;
   localparam int P2_UNIT_US   = 100;
   localparam int P2_UNIT_CYC  = P2_UNIT_US * CYC_PER_US;
   localparam int PRES_MS      = 50;
   localparam int PRES_CYC     = PRES_MS * (CLK_HZ / 1000);
   localparam int BYTE_US      = 8;
   localparam int BYTE_CYC     = BYTE_US * CYC_PER_US;
   localparam logic [1:0] BOOT_CYC = 2'h3;
   // Register byte addresses
   localparam logic [7:0] ADDR_CMD    = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_CFG    = 8'h08;
   localparam logic [7:0] ADDR_EVT    = 8'h0C;
   // Discovery configuration fields
   localparam int CFG_STOP_BIT  = 7;
   localparam int CFG_RETRY_LSB = 8;
   localparam int CFG_P2_LSB    = 16;
   localparam logic [31:0] CFG_RST = 32'h000A_017F;
   // Status fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_PREV_LSB  = 4;
   localparam int ST_PHASE_LSB = 8;
   localparam int ST_TEST_BIT  = 12;
   localparam int ST_USB_BIT   = 13;
   localparam int ST_CARD_BIT  = 14;
   // Event flags
   localparam int EV_ARRIVE = 0;
   localparam int EV_REMOVE = 1;
   // Host commands
   localparam logic [7:0] CMD_RF_ON   = 8'h01;
   localparam logic [7:0] CMD_RF_OFF  = 8'h02;
   localparam logic [7:0] CMD_ACT     = 8'h03;
   localparam logic [7:0] CMD_OPEN    = 8'h04;
   localparam logic [7:0] CMD_PWR_DN  = 8'h05;
   // Test transmit framing codes
   localparam logic [1:0] TXF_A106 = 2'h0;
   localparam logic [1:0] TXF_F212 = 2'h1;
   localparam logic [1:0] TXF_F424 = 2'h2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;

   typedef enum logic [2:0] {ST_STANDBY, ST_SUSPEND, ST_DISC, ST_READER, ST_TRANSP} roc_state_e;
   typedef enum logic [2:0] {PH_A, PH_P1, PH_4B, PH_BP, PH_2B, PH_F424, PH_F212, PH_P2} roc_phase_e;
endpackage : roc_pkg

// ---- rtl/roc_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module roc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            meta_r[i] <= 1'b0;
            dout[i]   <= 1'b0;
         end else begin
            meta_r[i] <= din[i];
            dout[i]   <= meta_r[i];
         end
      end
   end
endmodule : roc_sync

// ---- rtl/roc_lfsr.sv ----
// Pseudo-random byte source for the RF test transmitter
`timescale 1ns/1ps
module roc_lfsr
   import roc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       step,
   output logic      [7:0] rnd_byte
);
   logic [15:0] lfsr_r;
   logic [15:0] lfsr_nxt;

   always_comb begin
      lfsr_nxt = lfsr_r;
      if (step) begin
         lfsr_nxt = {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? LFSR_TAPS : 16'h0000);
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         lfsr_r <= LFSR_SEED;
      end else begin
         lfsr_r <= lfsr_nxt;
      end
   end

   assign rnd_byte = lfsr_r[7:0];
endmodule : roc_lfsr

// ---- dv/roc_front_model.sv ----
// Contactless front-end stand-in that answers discovery probes
`timescale 1ns/1ps
module roc_front_model (
   input  wire logic clk,
   input  wire logic probe_en,
   input  wire logic presence_chk,
   input  wire logic arm,
   input  wire logic gone,
   output logic      card_activated = 1'h0,
   output logic      card_absent = 1'h0
);
   int wait_r = 0;
   // Card answers a few cycles into a probe, not at once
   always @(posedge clk) begin
      card_activated <= arm && probe_en && wait_r == 3;
      wait_r <= (arm && probe_en) ? wait_r + 1 : 0;
      card_absent <= gone && presence_chk;
   end
endmodule : roc_front_model

// ---- dv/reader_operating_state_control_tb.sv ----
// Self-checking bench for the operating-state controller
`timescale 1ns/1ps
module reader_operating_state_control_tb;
   import roc_pkg::*;
   logic clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, mode_sel_pin_a = 1, mode_sel_pin_b = 1;
   logic tx_select_pin_a = 0, tx_select_pin_b = 0, link_is_usb = 1, usb_suspend = 0;
   logic uart_wake = 0, arm = 0, gone = 0, mon = 0, ord = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic rf_field_on, tx_valid, temp_sensor_en, cpu_low_power, gpio_park, probe_en;
   logic presence_chk, card_answer_to_reset, card_activated, card_absent;
   logic [1:0] s_axi_bresp, s_axi_rresp, tx_framing, r, wb;
   logic [2:0] op_state, probe_tech, lt;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [7:0] tx_data, en = 8'h7F, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_rdata, d, s_axi_wdata = 32'h0;
   int fail_count = 0, n_tests = 0, cyc = 0, st, p, seed = 32'h83b3;
   int cl[14] = '{2, 5, 3, 1, 4, 4, 3, 4, 1, 4, 2, 1, 3, 5};
   roc_ctrl #(.PRES_CYCLES(50)) i_roc_ctrl (.*);
   roc_front_model i_roc_front_model (.clk(clk), .probe_en(probe_en),
      .presence_chk(presence_chk), .arm(arm), .gone(gone),
      .card_activated(card_activated), .card_absent(card_absent));
   always #50 clk = ~clk;
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task results;
      $display("mismatches %0d comparisons %0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // Bounded run: a hang counts as a mismatch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         results();
      end
   end
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
      wb = s_axi_bresp;
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask : rd
   task rst(input logic u, input logic a, input logic b, input logic ta, input logic tb);
      @(posedge clk);
      sys_rst <= 1'h1;
      link_is_usb <= u;
      mode_sel_pin_a <= a;
      mode_sel_pin_b <= b;
      tx_select_pin_a <= ta;
      tx_select_pin_b <= tb;
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      repeat (5) @(posedge clk);
      st = (u && a) ? 2 : 0;
      @(negedge clk);
   endtask : rst
   task ws(input int s);
      repeat (20) begin
         @(negedge clk);
         if (op_state == s) break;
      end
      chk(op_state, s);
   endtask : ws
   task wt(input int w, input int n);
      repeat (n) begin
         @(negedge clk);
         if ((w == 0 && card_answer_to_reset) || (w == 1 && presence_chk)) break;
         if (w == 2 && tx_valid) break;
      end
   endtask : wt
   // Reference transition table of the operating machine
   function int mdl(input int s, input int c, input logic u);
      if (c == 5 && !u) return 1;
      if (c == 4) return (s == 4) ? (u ? 2 : 0) : 4;
      if (c == 3 && (s == 0 || s == 2)) return 3;
      if (c == 2 && (s == 2 || s == 3)) return 0;
      if (c == 1 && u && (s == 0 || s == 3)) return 2;
      return s;
   endfunction : mdl
   task cmds;
      foreach (cl[i]) begin
         wr(ADDR_CMD, 32'(cl[i]));
         p = st;
         st = mdl(st, cl[i], link_is_usb);
         ws(st);
         if (st == 3) chk(presence_chk, 0);
         if (st == 1) begin
            @(posedge clk) uart_wake <= 1'h1;
            ws(p);
            @(posedge clk) uart_wake <= 1'h0;
            st = p;
         end
      end
   endtask : cmds
   // Phase order, dark pauses and phase enables while looping
   always @(negedge clk) if (mon) begin
      if (ord && probe_tech !== lt) chk(probe_tech, 3'(lt + 3'h1));
      lt = probe_tech;
      if (probe_tech == 1 || probe_tech == 7) chk(rf_field_on, 0);
      if (!ord) chk(probe_en, en[probe_tech] && probe_tech != 1 && probe_tech != 7);
   end
   initial begin
      rst(1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
      ws(2);
      chk(cpu_low_power, 0);
      rd(ADDR_CFG);
      chk(d, CFG_RST);
      rd(8'h10);
      chk(r, RESP_SLVERR);
      wr(8'h10, 32'h0);
      chk(wb, RESP_SLVERR);
      cmds();
      @(posedge clk) usb_suspend <= 1'h1;
      ws(1);
      chk(gpio_park, 1);
      @(posedge clk) usb_suspend <= 1'h0;
      ws(3);
      wr(ADDR_CMD, 32'h1);
      wr(ADDR_CFG, 32'h0000_017F);
      chk(wb, RESP_OKAY);
      @(posedge clk) arm <= 1'h1;
      wt(0, 2000);
      chk(card_answer_to_reset, 1);
      @(posedge clk) arm <= 1'h0;
      gone <= 1'h1;
      wt(1, 60);
      chk(presence_chk, 1);
      @(posedge clk) gone <= 1'h0;
      rd(ADDR_EVT);
      chk(d[1:0], 2'h3);
      rd(ADDR_STATUS);
      chk(d[14:8], 7'h20);
      wr(ADDR_EVT, 32'h3);
      rd(ADDR_EVT);
      chk(d[1:0], 2'h0);
      lt = probe_tech;
      mon = 1;
      repeat (7200) @(posedge clk);
      mon = 0;
      en = {1'h0, 7'($random(seed))};
      wr(ADDR_CFG, {24'h000001, en});
      ord = 0;
      mon = 1;
      repeat (3000) @(posedge clk);
      mon = 0;
      wr(ADDR_CFG, 32'h0000_0180);
      @(negedge clk);
      chk(probe_en, 0);
      chk(rf_field_on, 0);
      rst(1'h0, 1'h1, 1'h1, 1'h0, 1'h0);
      ws(0);
      chk(rf_field_on, 0);
      cmds();
      for (int k = 0; k < 4; k++) begin
         rst(1'h1, 1'h0, 1'h1, k[1], k[0]);
         chk(tx_framing, (k == 3) ? 32'(TXF_A106) : k);
         chk(temp_sensor_en, 0);
         chk(rf_field_on, 1);
         wt(2, 100);
         chk(tx_valid, 1);
         chk(tx_data, 32'(LFSR_SEED[7:0]));
      end
      results();
   end
endmodule : reader_operating_state_control_tb
